/* core/aud_bclk.sv */
// Purpose: bit clock source or receiver, yields launch and sample pulses
// Assumes: received clock is asynchronous to clk
// Notes: generated clock is 50 percent duty
module aud_bclk
	import aud_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic master,
	input wire logic inv,
	input wire logic bclk_i,
	output logic bclk_o,
	output logic launch,
	output logic sample
);
	logic [2:0] sy_q, sy_d;
	logic [3:0] cnt_q, cnt_d;
	logic clk_q, clk_d;
	logic rise, fall;

	always_comb begin
		sy_d = {sy_q[1:0], bclk_i};
		cnt_d = cnt_q;
		clk_d = clk_q;
		rise = 1'b0;
		fall = 1'b0;
		if (master) begin
			// equal halves keep both phases well over 0.35 period
			if (cnt_q == AUD_HALF - 4'h1) begin // RULE12 RULE1
				cnt_d = 4'h0;
				clk_d = !clk_q;
				rise = !clk_q;
				fall = clk_q;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end else begin
			cnt_d = 4'h0;
			clk_d = 1'b0;
			rise = sy_q[1] & !sy_q[2];
			fall = !sy_q[1] & sy_q[2];
		end
		launch = ce & (inv ? fall : rise); // RULE9 RULE13
		sample = ce & (inv ? rise : fall); // RULE9 RULE13
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sy_q <= 3'h0;
			cnt_q <= 4'h0;
			clk_q <= 1'b0;
		end else if (ce) begin
			sy_q <= sy_d;
			cnt_q <= cnt_d;
			clk_q <= clk_d;
		end
	end

	assign bclk_o = clk_q;
endmodule

/* core/aud_port_dev.sv */
// Purpose: configurable i2s / pcm audio port, device end
// Assumes: cfg held steady while a frame runs
// Notes: slave locks on the first sync edge; the frame before is lost
module aud_port_dev
	import aud_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input aud_cfg_t cfg,
	input aud_smp_t [AUD_SLOTS-1:0] tx_smp,
	output logic tx_take,
	output aud_smp_t [AUD_SLOTS-1:0] rx_smp,
	output logic rx_valid,
	output logic frame_start,
	aud_link_if.dev link
);
	logic launch, sample, bclk_o;
	logic [6:0] pos_q, pos_d, pn, pc, dl, ds;
	aud_smp_t [AUD_SLOTS-1:0] tx_q, tx_d, rx_q, rx_d, src;
	aud_word_t sh_q, sh_d;
	logic sd_q, sd_d, oe_q, oe_d, sync_q, sync_d;
	logic pact_q, pact_d, rv_q, rv_d, fs_q, fs_d, act, start;
	logic [2:0] sy_q, sy_d;
	logic [1:0] d_q, d_d;

	// serial bit for word position b, fill per justification
	function automatic logic word_bit(input aud_smp_t s,
		input aud_cfg_t c, input logic [4:0] b);
		int n, i;
		logic fill;
		n = int'(aud_sbits(c.width)); // RULE10
		i = int'(b);
		fill = (c.pcm & c.sign_ext) ? s[n-1] : 1'b0; // RULE6 RULE8
		if (c.right_just) begin // RULE5
			if (i >= AUD_WORD - n)
				return s[AUD_WORD-1-i];
			return fill;
		end
		if (i < n)
			return s[n-1-i];
		return fill;
	endfunction

	function automatic logic in_smp(input aud_cfg_t c,
		input logic [4:0] b);
		int n;
		n = int'(aud_sbits(c.width));
		if (c.right_just)
			return int'(b) >= AUD_WORD - n;
		return int'(b) < n;
	endfunction

	// sample returned right aligned, upper bits zero
	function automatic aud_smp_t extract(input aud_word_t w,
		input aud_cfg_t c);
		aud_smp_t r;
		int n;
		r = '0;
		n = int'(aud_sbits(c.width)); // RULE10
		for (int i = 0; i < AUD_SMP; i++) begin
			if (i < n)
				r[i] = c.right_just ? w[i] : w[AUD_WORD-n+i]; // RULE5
		end
		return r;
	endfunction

	aud_bclk u_clk (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.master(cfg.master),
		.inv(cfg.clk_inv),
		.bclk_i(link.bclk),
		.bclk_o(bclk_o),
		.launch(launch),
		.sample(sample)
	);

	// index of the slot that closes a frame
	function automatic logic [1:0] last_slot(input aud_cfg_t c);
		return c.pcm ? c.slots : 2'h1; // RULE11
	endfunction

	assign act = aud_act(cfg, sy_q[1]);
	assign start = !cfg.master && act && !pact_q;
	assign pn = aud_pnext(cfg, pos_q); // RULE11 RULE17
	assign dl = aud_didx(cfg, pn); // RULE2
	assign pc = start ? 7'h00 : pos_q;
	assign ds = aud_didx(cfg, pc); // RULE2

	// two stages before any logic reads a pin
	always_comb begin
		sy_d = {sy_q[1:0], link.sync};
		d_d = {d_q[0], link.far_sd};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sy_q <= 3'h0;
			d_q <= 2'h0;
		end else if (ce) begin
			sy_q <= sy_d;
			d_q <= d_d;
		end
	end

	// position, sync and transmit side
	always_comb begin
		pos_d = pos_q;
		tx_d = tx_q;
		sd_d = sd_q;
		oe_d = oe_q;
		sync_d = sync_q;
		pact_d = pact_q;
		tx_take = 1'b0;
		src = tx_q;
		if (launch) begin
			pos_d = pn;
			if (dl == 7'h00) begin
				// new frame of samples taken as its first bit leaves
				tx_take = 1'b1;
				tx_d = tx_smp;
				src = tx_smp;
			end
			sd_d = word_bit(src[dl[6:5]], cfg, dl[4:0]); // RULE13
			// float only on pcm fill bits, set on the launch edge
			oe_d = !(cfg.pcm & cfg.tri_end & // RULE7 RULE8
				!in_smp(cfg, dl[4:0])); // RULE14
			// held relative to the idle level, so reset shows sync idle
			sync_d = aud_sync(cfg, pn) ^ // RULE4 RULE2 RULE13
				(cfg.pcm & !cfg.sync_pol); // RULE18
		end
		if (sample) begin
			pact_d = act;
			pos_d = pc; // RULE18
		end
	end

	// reset holds link outputs idle and counters cleared
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin // RULE18
			pos_q <= 7'h00;
			tx_q <= '0;
			sd_q <= 1'b0;
			oe_q <= 1'b0;
			sync_q <= 1'b0;
			pact_q <= 1'b0;
		end else if (ce) begin
			pos_q <= pos_d;
			tx_q <= tx_d;
			sd_q <= sd_d;
			oe_q <= oe_d;
			sync_q <= sync_d;
			pact_q <= pact_d;
		end
	end

	// frame marker: master at position 0, slave at each sync edge into the active level
	always_comb begin
		fs_d = 1'b0;
		if (launch && pn == 7'h00)
			fs_d = cfg.master;
		if (sample && start)
			fs_d = 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			fs_q <= 1'b0;
		else if (ce)
			fs_q <= fs_d;
	end

	// receive side
	always_comb begin
		sh_d = sh_q;
		rx_d = rx_q;
		rv_d = 1'b0;
		if (sample) begin
			sh_d = {sh_q[AUD_WORD-2:0], d_q[1]}; // RULE13 RULE16
			if (ds[4:0] == AUD_LAST_BIT) begin // RULE17
				rx_d[ds[6:5]] = extract(sh_d, cfg);
				rv_d = ds[6:5] == last_slot(cfg); // RULE11
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= '0;
			sh_q <= '0;
			rv_q <= 1'b0;
		end else if (ce) begin
			rx_q <= rx_d;
			sh_q <= sh_d;
			rv_q <= rv_d;
		end
	end

	assign link.dev_bclk_o = bclk_o;
	assign link.dev_bclk_oe = cfg.master; // RULE3
	assign link.dev_sync_o = sync_q ^ (cfg.pcm & !cfg.sync_pol);
	assign link.dev_sync_oe = cfg.master; // RULE3
	assign link.dev_sd_o = sd_q;
	assign link.dev_sd_oe = oe_q;
	assign rx_smp = rx_q;
	assign rx_valid = rv_q;
	assign frame_start = fs_q;
endmodule

/* core/aud_port_far.sv */
// Purpose: far end of the link, moves raw channel words
// Assumes: configured to match the port, master role opposite
// Notes: no justification here; words go out as given
module aud_port_far
	import aud_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input aud_cfg_t cfg,
	input aud_word_t [AUD_SLOTS-1:0] tx_word,
	output logic tx_take,
	output aud_word_t [AUD_SLOTS-1:0] rx_word,
	output logic rx_valid,
	aud_link_if.far link
);
	logic launch, sample, bclk_o;
	logic [6:0] pos_q, pos_d, pn, pc, dl, ds;
	aud_word_t [AUD_SLOTS-1:0] tx_q, tx_d, rx_q, rx_d;
	aud_word_t sh_q, sh_d;
	logic sd_q, sd_d, sync_q, sync_d, pact_q, pact_d, rv_q, rv_d, act;
	logic [2:0] sy_q, sy_d;
	logic [1:0] d_q, d_d;

	aud_bclk u_clk (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.master(cfg.master),
		.inv(cfg.clk_inv),
		.bclk_i(link.bclk),
		.bclk_o(bclk_o),
		.launch(launch),
		.sample(sample)
	);

	always_comb begin
		sy_d = {sy_q[1:0], link.sync};
		d_d = {d_q[0], link.dev_sd};
		pos_d = pos_q;
		tx_d = tx_q;
		rx_d = rx_q;
		sh_d = sh_q;
		sd_d = sd_q;
		sync_d = sync_q;
		pact_d = pact_q;
		rv_d = 1'b0;
		tx_take = 1'b0;
		act = aud_act(cfg, sy_q[1]);
		pn = aud_pnext(cfg, pos_q);
		dl = aud_didx(cfg, pn);
		pc = (!cfg.master && act && !pact_q) ? 7'h00 : pos_q;
		ds = aud_didx(cfg, pc);
		if (launch) begin
			// data and sync change away from the sampling edge
			pos_d = pn;
			sync_d = aud_sync(cfg, pn) ^ (cfg.pcm & !cfg.sync_pol); // RULE15
			if (dl == 7'h00) begin
				tx_take = 1'b1;
				tx_d = tx_word;
				sd_d = tx_word[0][AUD_WORD-1]; // RULE16
			end else begin
				sd_d = tx_q[dl[6:5]][~dl[4:0]]; // RULE16
			end
		end
		if (sample) begin
			pact_d = act;
			pos_d = pc; // RULE18
			sh_d = {sh_q[AUD_WORD-2:0], d_q[1]};
			if (ds[4:0] == AUD_LAST_BIT) begin
				rx_d[ds[6:5]] = sh_d;
				rv_d = ds[6:5] == (cfg.pcm ? cfg.slots : 2'h1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pos_q <= 7'h00;
			tx_q <= '0;
			rx_q <= '0;
			sh_q <= '0;
			sd_q <= 1'b0;
			sync_q <= 1'b0;
			pact_q <= 1'b0;
			rv_q <= 1'b0;
			sy_q <= 3'h0;
			d_q <= 2'h0;
		end else if (ce) begin
			pos_q <= pos_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			sh_q <= sh_d;
			sd_q <= sd_d;
			sync_q <= sync_d;
			pact_q <= pact_d;
			rv_q <= rv_d;
			sy_q <= sy_d;
			d_q <= d_d;
		end
	end

	assign link.far_bclk_o = bclk_o;
	assign link.far_bclk_oe = cfg.master; // RULE3
	assign link.far_sync_o = sync_q ^ (cfg.pcm & !cfg.sync_pol);
	assign link.far_sync_oe = cfg.master;
	assign link.far_sd_o = sd_q;
	assign link.far_sd_oe = 1'b1;
	assign rx_word = rx_q;
	assign rx_valid = rv_q;
endmodule

/* pkg/aud_link_if.sv */
// Purpose: the four-wire link between the port and its far end
// Assumes: bit clock and sync each driven by at most one end
// Notes: an undriven wire reads low here
interface aud_link_if;
	logic dev_bclk_o;
	logic dev_bclk_oe;
	logic dev_sync_o;
	logic dev_sync_oe;
	logic dev_sd_o;
	logic dev_sd_oe;
	logic far_bclk_o;
	logic far_bclk_oe;
	logic far_sync_o;
	logic far_sync_oe;
	logic far_sd_o;
	logic far_sd_oe;
	logic bclk;
	logic sync;
	logic dev_sd;
	logic far_sd;

	assign bclk = dev_bclk_oe ? dev_bclk_o : (far_bclk_oe & far_bclk_o);
	assign sync = dev_sync_oe ? dev_sync_o : (far_sync_oe & far_sync_o);
	assign dev_sd = dev_sd_oe & dev_sd_o;
	assign far_sd = far_sd_oe & far_sd_o;

	modport dev(output dev_bclk_o, dev_bclk_oe, dev_sync_o, dev_sync_oe,
		dev_sd_o, dev_sd_oe, input bclk, sync, far_sd);
	modport far(output far_bclk_o, far_bclk_oe, far_sync_o, far_sync_oe,
		far_sd_o, far_sd_oe, input bclk, sync, dev_sd);
endinterface

/* pkg/aud_pkg.sv */
// Purpose: shared constants, types and helpers for the serial audio port
// Assumes: 25 MHz clk; one clock enable freezes every end
// Notes: channel word is always AUD_WORD bits wide, MSB first
// How it works
// (RULE1) frames up to 384 kHz sample rate; bit clock is clk/16 here, so at most 48.8 kHz
// (RULE2) sync at first bit, or one before
// (RULE3) either end masters clock and sync
// (RULE4) pcm sync long or short, polarity selectable
// (RULE5) samples left or right justified in word
// (RULE6) pcm fill bits sign extended or zero
// (RULE7) pcm output may float after sample bits
// (RULE8) i2s never floats, fill bits are zero
// (RULE9) clock inversion swaps every active edge
// (RULE10) sample width 13, 16 or 24 bits
// (RULE11) pcm frame holds one to four slots
// (RULE12) clock high and low each >=0.35 period
// (RULE13) launch on rising edge, sample on falling
// (RULE14) master output floats on launch edge
// (RULE15) far master keeps sync stable at falling
// (RULE16) far end keeps data stable at falling
// (RULE17) pcm slots packed back to back
// (RULE18) counters restart on sync edge, idle in reset
package aud_pkg;
	localparam int AUD_WORD = 32;
	localparam int AUD_SMP = 24;
	localparam int AUD_SLOTS = 4;
	localparam int AUD_CLK_HZ = 25_000_000;
	localparam int AUD_FS_MAX_HZ = 384_000;
	// half period of a generated bit clock, in clk cycles
	localparam logic [3:0] AUD_HALF = 4'h8;
	localparam logic [4:0] AUD_LAST_BIT = 5'h1f;
	localparam logic [7:0] AUD_I2S_FLEN = 8'h40;

	typedef enum logic [1:0] {
		AUD_W13 = 2'b00,
		AUD_W16 = 2'b01,
		AUD_W24 = 2'b10
	} aud_width_t;

	typedef struct packed {
		logic pcm;
		logic master;
		logic sync_pol;
		logic sync_long;
		logic right_just;
		logic sign_ext;
		logic tri_end;
		logic clk_inv;
		aud_width_t width;
		logic [1:0] slots;
	} aud_cfg_t;

	typedef logic [AUD_SMP-1:0] aud_smp_t;
	typedef logic [AUD_WORD-1:0] aud_word_t;

	function automatic logic [4:0] aud_sbits(input aud_width_t w);
		unique case (w)
			AUD_W13: return 5'hd;
			AUD_W16: return 5'h10;
			AUD_W24: return 5'h18;
			default: return 5'h10;
		endcase
	endfunction

	function automatic logic [7:0] aud_flen(input aud_cfg_t c);
		// add after widening: four slots must not wrap to zero
		return c.pcm ? ({1'b0, c.slots, 5'h00} + 8'h20) : AUD_I2S_FLEN;
	endfunction

	// data index lags the frame position by one bit in i2s
	function automatic logic [6:0] aud_didx(input aud_cfg_t c,
		input logic [6:0] pos);
		logic [7:0] l;
		l = aud_flen(c) - 8'h01;
		if (c.pcm)
			return pos;
		return (pos == 7'h00) ? l[6:0] : pos - 7'h01;
	endfunction

	function automatic logic [6:0] aud_pnext(input aud_cfg_t c,
		input logic [6:0] pos);
		logic [7:0] l;
		l = aud_flen(c) - 8'h01;
		return ({1'b0, pos} == l) ? 7'h00 : pos + 7'h01;
	endfunction

	function automatic logic aud_sync(input aud_cfg_t c,
		input logic [6:0] pos);
		logic act;
		if (!c.pcm)
			return pos >= 7'h20;
		act = c.sync_long ? (pos < 7'h20) : (pos == 7'h00);
		return act ? c.sync_pol : !c.sync_pol;
	endfunction

	function automatic logic aud_act(input aud_cfg_t c, input logic s);
		return c.pcm ? (s == c.sync_pol) : !s;
	endfunction
endpackage

/* verif/aud_link_checker.sv */
// Purpose: wire-level checks on the link between the two ends
// Assumes: cfg is the device end's setting, changed only in reset
// Notes: the far end is master whenever the device end is not
module aud_link_checker
	import aud_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire aud_cfg_t cfg,
	input wire logic dev_bclk_o,
	input wire logic dev_bclk_oe,
	input wire logic dev_sync_o,
	input wire logic dev_sync_oe,
	input wire logic dev_sd_o,
	input wire logic dev_sd_oe,
	input wire logic far_bclk_oe,
	input wire logic bclk
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_launch;
		cfg.clk_inv ? $fell(dev_bclk_o) : $rose(dev_bclk_o);
	endsequence

	a_oe_master: assert property (dev_bclk_oe == cfg.master &&
		dev_sync_oe == cfg.master) else $error("clock or sync enable wrong");
	a_one_driver: assert property (far_bclk_oe != dev_bclk_oe)
		else $error("bit clock driven by both or neither end");
	a_sync_launch: assert property (cfg.master &&
		$changed(dev_sync_o) |-> s_launch) else $error("sync moved off edge");
	a_data_launch: assert property (cfg.master &&
		$changed(dev_sd_o) |-> s_launch) else $error("data moved off edge");
	a_float_launch: assert property (cfg.master && cfg.pcm &&
		$fell(dev_sd_oe) |-> s_launch) else $error("float off edge");
	a_i2s_drive: assert property (!cfg.pcm && dev_sd_oe |=>
		dev_sd_oe) else $error("i2s data floated");
	a_pcm_hold: assert property (cfg.pcm && !cfg.tri_end &&
		dev_sd_oe |=> dev_sd_oe) else $error("data floated without option");
	a_short_sync: assert property (cfg.master && cfg.pcm &&
		!cfg.sync_long && $changed(dev_sync_o) && dev_sync_o == cfg.sync_pol
		|-> ##15 dev_sync_o == cfg.sync_pol ##1 dev_sync_o != cfg.sync_pol)
		else $error("short sync not one bit long");
	// 6 of 16 cycles leaves margin over the 0.35 floor
	a_clk_high: assert property ($rose(bclk) |-> bclk[*6])
		else $error("bit clock high phase short");
	a_clk_low: assert property ($fell(bclk) |-> !bclk[*6])
		else $error("bit clock low phase short");

	c_tri: cover property (cfg.pcm && $fell(dev_sd_oe));
	c_i2s: cover property (!cfg.pcm && $fell(dev_sync_o));
	c_slave: cover property (!cfg.master && $rose(bclk));
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench for the device end and the far end
// Assumes: far end takes the opposite master role, other settings shared
// Notes: first two frames after each reset are lock-in, not compared
module testbench
	import aud_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam aud_cfg_t TBL [7] = '{12'h404, 12'h098, 12'he40, 12'h9e7,
		12'hcb9, 12'hf46, 12'hac0};
	logic clk;
	logic resetn;
	logic dev_take, far_take, dev_valid, far_valid, frame_start;
	logic [31:0] st = 32'h0000_b73a;
	aud_cfg_t cfg, cfg_far;
	aud_smp_t [AUD_SLOTS-1:0] tx_smp, rx_smp, dev_exp, dev_e;
	aud_word_t [AUD_SLOTS-1:0] tx_word, rx_word, far_exp, far_e;
	aud_smp_t [AUD_SLOTS-1:0] dev_q [$];
	aud_word_t [AUD_SLOTS-1:0] far_q [$];
	int n_mismatch = 0, checked = 0, dev_n = 0, far_n = 0, nsl;

	aud_link_if link ();
	aud_port_dev u_aud_port_dev (.clk(clk), .resetn(resetn), .ce(1'b1),
		.cfg(cfg), .tx_smp(tx_smp), .tx_take(dev_take), .rx_smp(rx_smp),
		.rx_valid(dev_valid), .frame_start(frame_start), .link(link.dev));
	aud_port_far u_aud_port_far (.clk(clk), .resetn(resetn), .ce(1'b1),
		.cfg(cfg_far), .tx_word(tx_word), .tx_take(far_take),
		.rx_word(rx_word), .rx_valid(far_valid), .link(link.far));
	aud_link_checker u_aud_link_checker (.clk(clk), .resetn(resetn),
		.cfg(cfg), .dev_bclk_o(link.dev_bclk_o),
		.dev_bclk_oe(link.dev_bclk_oe), .dev_sync_o(link.dev_sync_o),
		.dev_sync_oe(link.dev_sync_oe), .dev_sd_o(link.dev_sd_o),
		.dev_sd_oe(link.dev_sd_oe), .far_bclk_oe(link.far_bclk_oe),
		.bclk(link.bclk));

	always_comb begin
		cfg_far = cfg;
		cfg_far.master = !cfg.master;
	end
	assign nsl = cfg.pcm ? int'(cfg.slots) : 1;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	function automatic int sbits(input aud_width_t w);
		return (w == AUD_W13) ? 13 : (w == AUD_W24) ? 24 : 16;
	endfunction

	// a floated fill bit reads as zero on the wire
	function automatic aud_word_t mkword(input aud_cfg_t c, input aud_smp_t v);
		int s;
		logic [31:0] m, f;
		s = sbits(c.width);
		m = (32'h0000_0001 << s) - 32'h0000_0001;
		f = (c.pcm && c.sign_ext && !c.tri_end && v[s-1]) ? ~m : '0;
		if (c.right_just)
			return (32'(v) & m) | f;
		return ((32'(v) & m) << (32 - s)) | (f >> s);
	endfunction

	function automatic aud_smp_t take(input aud_cfg_t c, input aud_word_t w);
		int s;
		s = sbits(c.width);
		if (c.right_just)
			return aud_smp_t'(w & ((32'h0000_0001 << s) - 32'h0000_0001));
		return aud_smp_t'(w >> (32 - s));
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// first data bit after the frame's sync edge, seen on the wire
	task automatic wire_check;
		logic act;
		act = cfg.pcm ? cfg.sync_pol : 1'b0;
		wait (link.sync !== act);
		wait (link.sync === act);
		repeat (cfg.pcm ? 1 : 2) begin
			if (cfg.clk_inv)
				@(posedge link.bclk);
			else
				@(negedge link.bclk);
		end
		check(32'(link.dev_sd), 32'(far_exp[0][31]));
	endtask

	always @(posedge clk) begin
		if (dev_take)
			far_q.push_back(far_exp);
		if (far_take)
			dev_q.push_back(dev_exp);
		// frame marker must fall inside the active sync
		if (frame_start)
			check(32'(link.sync), 32'(cfg.pcm ? cfg.sync_pol : 1'b0));
		if (dev_valid) begin
			if (dev_n > 1 && dev_q.size() > 0) begin
				dev_e = dev_q.pop_front();
				for (int k = 0; k <= nsl; k++)
					check(32'(rx_smp[k]), 32'(dev_e[k]));
			end
			dev_n++;
		end
		if (far_valid) begin
			if (far_n > 1 && far_q.size() > 0) begin
				far_e = far_q.pop_front();
				for (int k = 0; k <= nsl; k++)
					check(rx_word[k], far_e[k]);
			end
			far_n++;
		end
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end

	initial begin
		#4_000_000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		cfg = TBL[0];
		tx_smp = '0;
		tx_word = '0;
		for (int i = 0; i < 7; i++) begin
			resetn = 1'b0;
			cfg = TBL[i];
			for (int k = 0; k < AUD_SLOTS; k++) begin
				st = xs(st);
				tx_smp[k] = st[23:0];
				st = xs(st);
				tx_word[k] = st;
				dev_exp[k] = take(cfg, st);
				far_exp[k] = mkword(cfg, tx_smp[k]);
			end
			dev_q.delete();
			far_q.delete();
			dev_n = 0;
			far_n = 0;
			repeat (3) @(posedge clk);
			#1 resetn = 1'b1;
			for (int t = 0; t < 20000 && (dev_n < 6 || far_n < 6); t++)
				@(posedge clk);
			check(32'(dev_n > 5 && far_n > 5), 32'h0000_0001);
			wire_check();
			$display("test %0d done", i);
			@(posedge clk);
			#1;
		end
		give_verdict();
	end
endmodule
